// [rtl/ssv_consts.svh]
/*
 * Constants of the dual rail supervisor: bus offsets, status field
 * positions, reset values, pin codes and delays.
 * Assumes a 100 MHz hclk; delays are given in ns and turned into cycles.
 */
`ifndef SSV_CONSTS_SVH
`define SSV_CONSTS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSV_CLK_NS 10
`define SSV_CYC(ns) (((ns) + `SSV_CLK_NS - 1) / `SSV_CLK_NS)
`define SSV_PG_ON_NS 1000000
`define SSV_PG_OFF_NS 10000
`define SSV_OVP_NS 10000
`define SSV_UVP_NS 1000000
`define SSV_SW5_NS 3800000
`define SSV_SW33_NS 4000000
`define SSV_SS_STEP_NS 200000
`define SSV_SS_LAST 3'h5
// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define SSV_CTRL_ADDR 8'h00
`define SSV_STAT_ADDR 8'h04
`define SSV_CTRL_RST 2'h0
`define SSV_ST_RAIL_OK 8
`define SSV_ST_LDO_ON 10
`define SSV_ST_SWITCHED 11
`define SSV_ST_SHUTDOWN 12
`define SSV_ST_REF2 13
`define SSV_ST_REF3 14
// ----------------------------------------------------------------
// Pin codes
// ----------------------------------------------------------------
`define SSV_LL_FORCED 2'h2
`define SSV_SET_5V 2'h0
`define SSV_SET_3V3 2'h1
`endif

// [rtl/ssv_pkg.sv]
/*
 * Types of the dual rail supervisor: channel state and the per-channel
 * comparator and driver bundles.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssv_pkg;
   // Channel sequencing states
   typedef enum logic [2:0] {ST_DIS, ST_SOFT, ST_RUN, ST_OVL, ST_UVL} ssv_state_e;
   // Digital comparator results and requests of one channel
   typedef struct packed {
      logic channel_on_request;
      logic start_after_other;
      logic on_demand;
      logic on_time_done;
      logic current_limit_trip;
      logic neg_limit_trip;
      logic zero_current;
      logic in_window;
      logic below_90;
      logic above_105;
      logic above_115;
      logic below_70;
      logic ref_reached;
   } ssv_chan_in_s;
   // Driver and flag outputs of one channel
   typedef struct packed {
      logic high_side_on;
      logic low_side_on;
      logic discharge_on;
      logic rail_ok_flag;
      logic forced_cont;
      logic [2:0] ilim_step;
   } ssv_chan_out_s;
endpackage : ssv_pkg

// [rtl/ssv_supervisor.sv]
/*
 * Sequencing and protection logic of a dual step-down controller with
 * a linear regulator, plus an AHB-Lite slave for control and status.
 * Assumes all comparator inputs are synchronous to hclk.
 */
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ssv_consts.svh"

module ssv_supervisor
   import ssv_pkg::*;
#(
   parameter int PG_ON_CYC = `SSV_CYC(`SSV_PG_ON_NS),
   parameter int UVP_CYC = `SSV_CYC(`SSV_UVP_NS),
   parameter int SW5_CYC = `SSV_CYC(`SSV_SW5_NS),
   parameter int SW33_CYC = `SSV_CYC(`SSV_SW33_NS),
   parameter int SS_STEP_CYC = `SSV_CYC(`SSV_SS_STEP_NS)
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire ssv_chan_in_s [1:0] ch_in,
   output ssv_chan_out_s [1:0] ch_out,
   input wire logic linear_reg_on_request,
   input wire logic supply_above_2v1,
   input wire logic supply_above_1v8,
   input wire logic bias_lockout,
   input wire logic over_temp,
   input wire logic [1:0] light_load_mode_select,
   input wire logic [1:0] linear_reg_setpoint_pin,
   input wire logic switchover_at_4v7,
   input wire logic switchover_at_3v15,
   output logic precision_reference_on,
   output logic two_volt_reference_on,
   output logic linear_reg_on,
   output logic switchover_on,
   output logic shutdown_state
);
   localparam logic [19:0] PG_OFF_CYC = 20'(`SSV_CYC(`SSV_PG_OFF_NS));
   localparam logic [19:0] OVP_CYC = 20'(`SSV_CYC(`SSV_OVP_NS));

   // Counters are 20 bits wide
   if (PG_ON_CYC < 1 || UVP_CYC < 1 || SW5_CYC < 1 || SW33_CYC < 1 ||
       SS_STEP_CYC < 1 || PG_ON_CYC > 1048575 || UVP_CYC > 1048575 ||
       SW5_CYC > 1048575 || SW33_CYC > 1048575 || SS_STEP_CYC > 1048575) begin : g_chk
      $error("ssv_supervisor: delay count out of range");
   end

   // Persistence counter: restarts when cause clears, saturates at limit
   function automatic logic [19:0] cnt_next(input logic [19:0] c, input logic cond,
                                            input logic [19:0] lim);
      if (!cond) begin
         return 20'h00000;
      end
      return (c >= lim) ? lim : c + 20'h00001;
   endfunction : cnt_next

   // ----------------------------------------------------------------
   // Channel sequencing and drivers
   // ----------------------------------------------------------------
   ssv_state_e st [2];
   ssv_state_e next_st [2];
   logic [19:0] pg_cnt [2], next_pg_cnt [2];
   logic [19:0] pgd_cnt [2], next_pgd_cnt [2];
   logic [19:0] ovp_cnt [2], next_ovp_cnt [2];
   logic [19:0] uvp_cnt [2], next_uvp_cnt [2];
   logic [19:0] ss_cnt [2], next_ss_cnt [2];
   logic [2:0] ss_step [2], next_ss_step [2];
   logic [1:0] seen_hs, next_seen_hs;
   logic [1:0] ref_ok, next_ref_ok;
   ssv_chan_out_s [1:0] next_ch_out;
   logic [1:0] ctrl_inhibit;
   logic [1:0] uvp_exp;
   logic [1:0] ovp_exp;

   // Next state of both channels
   always_comb begin
      logic prot, en, go, fc, act, ovp_any;
      prot = bias_lockout | over_temp;
      en = 1'b0;
      go = 1'b0;
      fc = 1'b0;
      act = 1'b0;
      ovp_any = 1'b0;
      for (int i = 0; i < 2; i++) begin
         next_ovp_cnt[i] = cnt_next(ovp_cnt[i], ch_in[i].above_115 &&
                           (st[i] == ST_SOFT || st[i] == ST_RUN), OVP_CYC);
         ovp_exp[i] = (next_ovp_cnt[i] == OVP_CYC) && ch_in[i].above_115 &&
                      (st[i] == ST_SOFT || st[i] == ST_RUN);
         next_uvp_cnt[i] = cnt_next(uvp_cnt[i], ch_in[i].below_70 && st[i] == ST_RUN,
                                    20'(UVP_CYC));
         uvp_exp[i] = (next_uvp_cnt[i] == 20'(UVP_CYC)) && ch_in[i].below_70 &&
                      st[i] == ST_RUN;
      end
      for (int i = 0; i < 2; i++) begin
         next_st[i] = st[i];
         next_ss_cnt[i] = ss_cnt[i];
         next_ss_step[i] = ss_step[i];
         next_seen_hs[i] = seen_hs[i];
         next_ref_ok[i] = ref_ok[i] | ch_in[i].ref_reached;
         en = ch_in[i].channel_on_request && !ctrl_inhibit[i];
         go = en && (!ch_in[i].start_after_other || ch_out[1 - i].rail_ok_flag);
         unique case (st[i])
            ST_DIS: begin
               if (go && !prot) begin
                  next_st[i] = ST_SOFT;
                  next_ss_cnt[i] = 20'h00000;
                  next_ss_step[i] = 3'h1;
                  next_seen_hs[i] = 1'b0;
                  next_ref_ok[i] = ch_in[i].ref_reached;
               end
            end
            ST_SOFT: begin
               // One fifth of full limit per step
               if (ss_cnt[i] >= 20'(SS_STEP_CYC - 1)) begin
                  next_ss_cnt[i] = 20'h00000;
                  if (ss_step[i] == `SSV_SS_LAST) begin
                     next_st[i] = ST_RUN;
                  end else begin
                     next_ss_step[i] = ss_step[i] + 3'h1;
                  end
               end else begin
                  next_ss_cnt[i] = ss_cnt[i] + 20'h00001;
               end
            end
            ST_RUN, ST_OVL, ST_UVL: begin
            end
         endcase
         if (uvp_exp[0] || uvp_exp[1]) begin
            next_st[i] = ST_UVL;
         end
         if (ovp_exp[i]) begin
            next_st[i] = ST_OVL;
         end
         if (!en || prot) begin
            next_st[i] = ST_DIS;
         end
      end
      ovp_any = (next_st[0] == ST_OVL) || (next_st[1] == ST_OVL);
      for (int i = 0; i < 2; i++) begin
         next_ch_out[i] = ch_out[i];
         // Skip modes fall back to continuous when above +5%
         fc = (light_load_mode_select == `SSV_LL_FORCED) || ch_in[i].above_105;
         next_ch_out[i].forced_cont = fc;
         next_ch_out[i].discharge_on = (next_st[i] == ST_DIS) || (next_st[i] == ST_UVL);
         next_ch_out[i].ilim_step = (next_st[i] == ST_SOFT) ? next_ss_step[i] :
                                    (next_st[i] == ST_RUN || next_st[i] == ST_OVL) ?
                                    `SSV_SS_LAST : 3'h0;
         act = (next_st[i] == ST_SOFT || next_st[i] == ST_RUN) && next_ref_ok[i];
         if (next_st[i] == ST_OVL) begin
            // Low side latched on, high side pulsed at negative limit
            if (ch_out[i].high_side_on) begin
               next_ch_out[i].high_side_on = !ch_in[i].on_time_done;
               next_ch_out[i].low_side_on = ch_in[i].on_time_done;
            end else if (ch_in[i].neg_limit_trip && !ch_in[i].current_limit_trip) begin
               next_ch_out[i].high_side_on = 1'b1;
               next_ch_out[i].low_side_on = 1'b0;
            end else begin
               next_ch_out[i].low_side_on = 1'b1;
            end
         end else if (!act) begin
            next_ch_out[i].high_side_on = 1'b0;
            next_ch_out[i].low_side_on = 1'b0;
         end else if (ch_out[i].high_side_on) begin
            if (ch_in[i].on_time_done) begin
               next_ch_out[i].high_side_on = 1'b0;
               next_ch_out[i].low_side_on = next_seen_hs[i];
            end
         end else if (!ch_in[i].current_limit_trip &&
                      (ch_in[i].on_demand || (fc && ch_in[i].neg_limit_trip))) begin
            next_ch_out[i].high_side_on = 1'b1;
            next_ch_out[i].low_side_on = 1'b0;
            next_seen_hs[i] = 1'b1;
         end else if (!fc && ch_in[i].zero_current) begin
            next_ch_out[i].low_side_on = 1'b0;
         end else begin
            next_ch_out[i].low_side_on = next_seen_hs[i];
         end
         // Rail-ok qualification, evaluated only after soft start
         next_pg_cnt[i] = cnt_next(pg_cnt[i], next_st[i] == ST_RUN && ch_in[i].in_window,
                                   20'(PG_ON_CYC));
         next_pgd_cnt[i] = cnt_next(pgd_cnt[i], ch_out[i].rail_ok_flag && ch_in[i].below_90,
                                    PG_OFF_CYC);
         if (next_pg_cnt[i] == 20'(PG_ON_CYC)) begin
            next_ch_out[i].rail_ok_flag = 1'b1;
         end
         if (next_pgd_cnt[i] == PG_OFF_CYC || next_st[i] != ST_RUN || ovp_any) begin
            next_ch_out[i].rail_ok_flag = 1'b0;
         end
      end
   end

   // Channel registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 2; i++) begin
            st[i] <= ST_DIS;
            pg_cnt[i] <= 20'h00000;
            pgd_cnt[i] <= 20'h00000;
            ovp_cnt[i] <= 20'h00000;
            uvp_cnt[i] <= 20'h00000;
            ss_cnt[i] <= 20'h00000;
            ss_step[i] <= 3'h0;
            ch_out[i] <= '{default: 1'b0, discharge_on: 1'b1};
         end
         seen_hs <= 2'h0;
         ref_ok <= 2'h0;
      end else begin
         st <= next_st;
         pg_cnt <= next_pg_cnt;
         pgd_cnt <= next_pgd_cnt;
         ovp_cnt <= next_ovp_cnt;
         uvp_cnt <= next_uvp_cnt;
         ss_cnt <= next_ss_cnt;
         ss_step <= next_ss_step;
         ch_out <= next_ch_out;
         seen_hs <= next_seen_hs;
         ref_ok <= next_ref_ok;
      end
   end

   // ----------------------------------------------------------------
   // References, linear regulator and switchover
   // ----------------------------------------------------------------
   logic [19:0] sw_cnt, next_sw_cnt;
   logic next_ref3, next_ref2, next_ldo_on, next_switch, next_shutdown;

   // Reference enables and timed switchover
   always_comb begin
      logic mode5, mode33, cond;
      logic [19:0] lim;
      mode5 = (linear_reg_setpoint_pin == `SSV_SET_5V);
      mode33 = (linear_reg_setpoint_pin == `SSV_SET_3V3);
      cond = linear_reg_on_request && ((mode5 && switchover_at_4v7) ||
             (mode33 && switchover_at_3v15));
      lim = mode5 ? 20'(SW5_CYC) : 20'(SW33_CYC);
      next_sw_cnt = cnt_next(sw_cnt, cond, lim);
      next_switch = cond && (switchover_on || next_sw_cnt == lim);
      next_ldo_on = linear_reg_on_request && !next_switch;
      next_ref3 = supply_above_2v1 | (precision_reference_on & supply_above_1v8);
      next_ref2 = linear_reg_on_request || ch_in[0].channel_on_request ||
                  ch_in[1].channel_on_request || st[0] != ST_DIS ||
                  st[1] != ST_DIS;
      next_shutdown = !ch_in[0].channel_on_request && !ch_in[1].channel_on_request &&
                      !linear_reg_on_request;
   end

   // Reference and regulator registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_cnt <= 20'h00000;
         switchover_on <= 1'b0;
         linear_reg_on <= 1'b0;
         precision_reference_on <= 1'b0;
         two_volt_reference_on <= 1'b0;
         shutdown_state <= 1'b1;
      end else begin
         sw_cnt <= next_sw_cnt;
         switchover_on <= next_switch;
         linear_reg_on <= next_ldo_on;
         precision_reference_on <= next_ref3;
         two_volt_reference_on <= next_ref2;
         shutdown_state <= next_shutdown;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   logic dp_wr, next_dp_wr;
   logic [7:0] dp_addr, next_dp_addr;
   logic [1:0] next_ctrl;
   logic [31:0] next_hrdata;

   // Address phase capture, write in data phase, read data registered
   always_comb begin
      logic ap;
      logic [1:0] ctrl_now;
      logic [31:0] stat;
      ap = hsel && htrans[1] && hready;
      next_dp_wr = ap && hwrite && haddr[31:8] == 24'h000000;
      next_dp_addr = haddr[7:0];
      next_ctrl = ctrl_inhibit;
      if (dp_wr && dp_addr == `SSV_CTRL_ADDR) begin
         next_ctrl = hwdata[1:0];
      end
      ctrl_now = next_ctrl;
      stat = 32'h00000000;
      stat[2:0] = st[0];
      stat[6:4] = st[1];
      stat[`SSV_ST_RAIL_OK +: 2] = {ch_out[1].rail_ok_flag, ch_out[0].rail_ok_flag};
      stat[`SSV_ST_LDO_ON] = linear_reg_on;
      stat[`SSV_ST_SWITCHED] = switchover_on;
      stat[`SSV_ST_SHUTDOWN] = shutdown_state;
      stat[`SSV_ST_REF2] = two_volt_reference_on;
      stat[`SSV_ST_REF3] = precision_reference_on;
      next_hrdata = 32'h00000000;
      if (ap && !hwrite && haddr[7:0] == `SSV_CTRL_ADDR && haddr[31:8] == 24'h000000) begin
         next_hrdata = {30'h00000000, ctrl_now};
      end else if (ap && !hwrite && haddr[7:0] == `SSV_STAT_ADDR &&
                   haddr[31:8] == 24'h000000) begin
         next_hrdata = stat;
      end
   end

   // Bus registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         ctrl_inhibit <= `SSV_CTRL_RST;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr <= next_dp_wr;
         dp_addr <= next_dp_addr;
         ctrl_inhibit <= next_ctrl;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_soft_entry;
      $past(st[0]) == ST_DIS ##0 st[0] == ST_SOFT;
   endsequence
   sequence s_soft_exit;
      $past(st[0]) == ST_SOFT ##0 st[0] == ST_RUN;
   endsequence

   a_soft_steps: assert property (s_soft_exit |-> $past(ch_out[0].ilim_step) == 3'h5)
      else $error("soft start ended before last step");
   a_first_hs: assert property (s_soft_entry |-> !ch_out[0].low_side_on)
      else $error("low side on before first high side pulse");
   a_shutdown: assert property ((!ch_in[0].channel_on_request && !ch_in[1].channel_on_request
      && !linear_reg_on_request) |=> shutdown_state)
      else $error("shutdown state missing");
   a_pg_delay: assert property ($rose(ch_out[0].rail_ok_flag) |->
      pg_cnt[0] == 20'(PG_ON_CYC) && st[0] == ST_RUN)
      else $error("rail ok rose early");
   a_pg_drop: assert property (pgd_cnt[0] == PG_OFF_CYC |-> !ch_out[0].rail_ok_flag)
      else $error("rail ok not dropped");
   a_disch_ls: assert property (ch_out[0].discharge_on |-> !ch_out[0].low_side_on)
      else $error("low side on during discharge");
   a_ref3_off: assert property (!supply_above_1v8 && !supply_above_2v1 |=>
      !precision_reference_on)
      else $error("precision reference stayed on");
   a_ocl_block: assert property (ch_in[0].current_limit_trip && !ch_out[0].high_side_on
      |=> !ch_out[0].high_side_on)
      else $error("on cycle started over current limit");
   a_ovp_flags: assert property ((st[0] == ST_OVL || st[1] == ST_OVL) |->
      !ch_out[0].rail_ok_flag && !ch_out[1].rail_ok_flag)
      else $error("rail ok high during overvoltage");
   a_uvp_latch: assert property (st[0] == ST_UVL |->
      !ch_out[0].high_side_on && !ch_out[0].low_side_on)
      else $error("drivers on after undervoltage latch");
endmodule : ssv_supervisor

// [test/ssv_rail_model.sv]
/* Far-side model of one channel: switching stage, on-time one-shot, rail.
   Assumes the bench sets the rail level in percent of its target. */
`timescale 1ns/1ps
module ssv_rail_model
   import ssv_pkg::*;
#(
   parameter int ON_CYC = 3
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ssv_chan_out_s drv,
   input wire logic enable,
   input wire logic strap,
   input wire logic ilim_hit,
   input wire logic [7:0] level,
   output ssv_chan_in_s cmp
);
   logic [3:0] on_cnt;
   // On-time length counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_cnt <= 4'h0;
      end else begin
         on_cnt <= drv.high_side_on ? on_cnt + 4'h1 : 4'h0;
      end
   end
   // Comparators derived from the rail level
   always_comb begin
      cmp = '0;
      cmp.channel_on_request = enable;
      cmp.start_after_other = strap;
      cmp.on_demand = level < 8'h64;
      cmp.on_time_done = on_cnt >= 4'(ON_CYC);
      cmp.current_limit_trip = ilim_hit;
      cmp.neg_limit_trip = drv.low_side_on && level > 8'h69;
      cmp.in_window = level >= 8'h5F;
      cmp.below_90 = level < 8'h5A;
      cmp.above_105 = level > 8'h69;
      cmp.above_115 = level > 8'h73;
      cmp.below_70 = level < 8'h46;
      cmp.ref_reached = 1'b1;
   end
endmodule : ssv_rail_model

// [test/ssv_supervisor_tb_top.sv]
/* Self-checking bench of the supervisor: AHB-Lite tasks and sequences.
   Assumes the rail model and short delay parameters. */
`timescale 1ns/1ps
`include "ssv_consts.svh"
module ssv_supervisor_tb_top
   import ssv_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, en, strap, ilim, mode, sp, sd;
   logic [2:0] hsize;
   wire ssv_chan_in_s [1:0] ch_in;
   ssv_chan_out_s [1:0] ch_out;
   logic [1:0][7:0] lvl;
   logic ldo_req, lockout, sw47, sw315, ref3, ref2, ldo_on, sw_on, shut, hot, sup21, sup18;
   int mismatches, total_checks, i;
   ssv_supervisor #(.PG_ON_CYC(20), .UVP_CYC(20), .SW5_CYC(30), .SW33_CYC(40),
      .SS_STEP_CYC(10)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_in(ch_in), .ch_out(ch_out),
      .linear_reg_on_request(ldo_req), .supply_above_2v1(sup21), .supply_above_1v8(sup18),
      .bias_lockout(lockout), .over_temp(hot), .light_load_mode_select(mode),
      .linear_reg_setpoint_pin(sp), .switchover_at_4v7(sw47), .switchover_at_3v15(sw315),
      .precision_reference_on(ref3), .two_volt_reference_on(ref2), .linear_reg_on(ldo_on),
      .switchover_on(sw_on), .shutdown_state(shut));
   // One rail model per channel
   for (genvar g = 0; g < 2; g++) begin : g_rail
      ssv_rail_model rail (.hclk(hclk), .hresetn(hresetn), .drv(ch_out[g]), .enable(en[g]),
         .strap(strap[g]), .ilim_hit(ilim[g]), .level(lvl[g]), .cmp(ch_in[g]));
   end
   task print_verdict;
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Driver activity of channel 0 over five clock cycles
   task seen_drv(output logic [1:0] s);
      s = 2'h0;
      repeat (5) begin
         @(posedge hclk);
         s = s | {ch_out[0].high_side_on, ch_out[0].low_side_on};
      end
   endtask : seen_drv
   // Edge at which hready is sampled high, bounded
   task wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20) begin
         n++;
         @(posedge hclk);
      end
      if (n == 20) begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_rdy
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, en, ilim, mode} = '0;
      {ldo_req, lockout, hot, sw47, sw315, mismatches, total_checks} = '0;
      {sup21, sup18} = 2'h3;
      hsize = 3'h2;
      strap = 2'h2;
      sp = 2'h2;
      lvl = {8'h61, 8'h61};
      cyc(2);
      hresetn <= 1'b1;
      cyc(2);
      chk(shut, 1'b1);
      chk(ch_out[0].discharge_on, 1'b1);
      chk(ref3, 1'b1);
      chk(ref2, 1'b0);
      // Supply hysteresis of the precision reference
      sup21 <= 1'b0;
      cyc(3);
      chk(ref3, 1'b1);
      sup18 <= 1'b0;
      cyc(3);
      chk(ref3, 1'b0);
      {sup21, sup18} <= 2'h3;
      cyc(3);
      chk(ref3, 1'b1);
      ahb(1'b1, 32'h0, 32'h3);
      ahb(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h3);
      ahb(1'b1, 32'h0, 32'h0);
      ahb(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h0);
      ldo_req <= 1'b1;
      cyc(3);
      chk(ref2, 1'b1);
      chk(shut, 1'b0);
      // Fixed 5 V, fixed 3.3 V, adjustable
      for (i = 0; i < 3; i++) begin
         sp <= 2'(i);
         sw47 <= (i != 1);
         sw315 <= (i != 0);
         cyc(i == 1 ? 35 : 25);
         chk(sw_on, 1'b0);
         cyc(10);
         chk(sw_on, i < 2);
         chk(ldo_on, i == 2);
         {sw47, sw315} <= 2'h0;
         cyc(3);
      end
      en <= 2'h3;
      for (i = 0; i < 5; i++) begin
         cyc(i == 0 ? 6 : 10);
         chk(ch_out[0].ilim_step, i + 1);
         chk(ch_out[1].ilim_step, 3'h0);
         chk(ch_out[0].rail_ok_flag, 1'b0);
      end
      cyc(15);
      chk(ch_out[0].rail_ok_flag, 1'b0);
      cyc(15);
      chk(ch_out[0].rail_ok_flag, 1'b1);
      cyc(3);
      chk(ch_out[1].ilim_step, 3'h1);
      for (i = 0; i < 4; i++) begin
         mode <= 2'(i);
         lvl[0] <= 8'h6B;
         cyc(4);
         chk(ch_out[0].forced_cont, 1'b1);
         lvl[0] <= 8'h61;
         cyc(4);
         chk(ch_out[0].forced_cont, i == 2);
      end
      mode <= 2'h0;
      ilim[0] <= 1'b1;
      cyc(5);
      for (i = 0; i < 4; i++) begin
         cyc(2);
         chk(ch_out[0].high_side_on, 1'b0);
      end
      ilim[0] <= 1'b0;
      lvl[0] <= 8'h55;
      cyc(990);
      chk(ch_out[0].rail_ok_flag, 1'b1);
      cyc(20);
      chk(ch_out[0].rail_ok_flag, 1'b0);
      // Channel 0 over 115%: negative limit pulses, then overvoltage latch
      lvl[0] <= 8'h78;
      cyc(20);
      chk(ch_out[1].rail_ok_flag, 1'b1);
      seen_drv(sd);
      chk(sd, 2'h3);
      cyc(980);
      chk(ch_out[1].rail_ok_flag, 1'b0);
      seen_drv(sd);
      chk(sd, 2'h3);
      ahb(1'b0, {24'h0, `SSV_STAT_ADDR}, 32'h0);
      chk(rd[2:0], 3'h3);
      lvl[1] <= 8'h3C;
      cyc(30);
      chk({ch_out[0].high_side_on, ch_out[0].low_side_on}, 2'h0);
      chk(ch_out[0].discharge_on, 1'b1);
      ahb(1'b0, {24'h0, `SSV_STAT_ADDR}, 32'h0);
      chk({rd[6:4], rd[2:0]}, 6'h24);
      en[0] <= 1'b0;
      lvl[0] <= 8'h61;
      cyc(3);
      en[0] <= 1'b1;
      cyc(3);
      ahb(1'b0, {24'h0, `SSV_STAT_ADDR}, 32'h0);
      chk({rd[6:4], rd[2:0]}, 6'h21);
      // Lockout, then over temperature: no latch, precision reference kept
      for (i = 0; i < 2; i++) begin
         {hot, lockout} <= 2'(i + 1);
         cyc(3);
         chk({ch_out[0].discharge_on, ch_out[0].low_side_on}, 2'h2);
         chk(ref3, 1'b1);
         {hot, lockout} <= 2'h0;
         cyc(3);
         chk(ch_out[0].ilim_step, 3'h1);
      end
      print_verdict();
   end
   // Watchdog
   initial begin
      cyc(5000);
      mismatches++;
      print_verdict();
   end
endmodule : ssv_supervisor_tb_top
